// *** tfr_pkg.sv ***
// Constants shared by the temperature fault retry logic
`default_nettype none
package tfr_pkg;
  // ----------------------------------------------------------------
  // Command codes of the registers
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OT_REACTION = 8'h50; // Fault reaction byte
  localparam logic [7:0] CMD_OT_WARN = 8'h51; // Over-temperature warning threshold
  localparam logic [7:0] CMD_UT_WARN = 8'h52; // Under-temperature warning threshold
  localparam logic [7:0] CMD_STATUS = 8'h7d; // Temperature status, write one to clear
  localparam logic [7:0] CMD_TIME_UNIT = 8'hd2; // Delay time unit in microseconds

  // ----------------------------------------------------------------
  // Field layout of the reaction byte
  // ----------------------------------------------------------------
  localparam int RESP_MSB = 7; // Response field
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5; // Retry setting field
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2; // Delay count field
  localparam int DELAY_LSB = 0;

  // Status bit positions
  localparam int ST_OT_WARN = 6; // Over-temperature warning
  localparam int ST_UT_WARN = 5; // Under-temperature warning
  localparam int ST_OT_FAULT = 7; // Over-temperature fault latched

  // ----------------------------------------------------------------
  // Codes of the fields
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_IGNORE = 2'h0; // Keep running
  localparam logic [1:0] RESP_DELAY = 2'h1; // Run for the delay, then retry setting
  localparam logic [1:0] RESP_RETRY = 2'h2; // Disable, then retry setting
  localparam logic [1:0] RESP_LATCH = 2'h3; // Disable until cleared
  localparam logic [2:0] RETRY_NONE = 3'h0; // No restart
  localparam logic [2:0] RETRY_FOREVER = 3'h7; // Unlimited restarts

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REACTION = 8'hb8; // Disable and retry forever, 1 unit
  localparam logic [15:0] RST_OT_WARN = 16'h0064; // Warning above this reading
  localparam logic [15:0] RST_UT_WARN = 16'hffd8; // Warning below this reading
  localparam logic [15:0] RST_TIME_UNIT = 16'h03e8; // 1000 us per unit

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8; // 125 MHz reference clock
  localparam int US_NS = 1000; // One microsecond
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS; // Cycles in one microsecond

  // Delay code to number of time units; code 4 has no listed value, 8 fills the gap
  function automatic logic [7:0] delay_units(input logic [2:0] code);
    case (code)
      3'h0: delay_units = 8'h01;
      3'h1: delay_units = 8'h02;
      3'h2: delay_units = 8'h04;
      3'h3: delay_units = 8'h10;
      3'h4: delay_units = 8'h08;
      3'h5: delay_units = 8'h20;
      3'h6: delay_units = 8'h40;
      default: delay_units = 8'h80;
    endcase
  endfunction
endpackage
`default_nettype wire

// *** tfr_timer.sv ***
// Delay timer counting whole time units of a programmable length
`default_nettype none
module tfr_timer #(
  parameter int CYC_US = tfr_pkg::CYC_PER_US
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [7:0] units_i,
  input wire logic [15:0] unit_us_i,
  output logic done_o
);
  // Refused at elaboration: the prescaler is eight bits and needs at least two states
  if (CYC_US < 2 || CYC_US > 255)
  begin : g_bad_cyc_us
    $error("tfr_timer: CYC_US out of range");
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  logic run; // Timer is counting
  logic [7:0] pre; // Microsecond prescaler
  logic [15:0] us_cnt; // Microseconds inside the current unit
  logic [7:0] unit_cnt; // Units left
  logic next_run;
  logic [7:0] next_pre;
  logic [15:0] next_us_cnt;
  logic [7:0] next_unit_cnt;
  logic next_done;
  logic us_tick; // One-cycle enable every microsecond

  // Next-state of the divider chain; a zero unit length counts as one us
  always_comb
  begin
    next_run = run;
    next_pre = pre;
    next_us_cnt = us_cnt;
    next_unit_cnt = unit_cnt;
    next_done = 1'b0;
    us_tick = (pre == 8'(CYC_US - 1));
    if (start_i)
    begin
      // Restart always wins, so each attempt gets a full interval
      next_run = 1'b1;
      next_pre = 8'h00;
      next_us_cnt = 16'h0000;
      next_unit_cnt = units_i;
    end
    else if (run)
    begin
      next_pre = us_tick ? 8'h00 : pre + 8'h01;
      if (us_tick)
      begin
        if (us_cnt + 16'h0001 >= unit_us_i)
        begin
          next_us_cnt = 16'h0000;
          if (unit_cnt <= 8'h01)
          begin
            next_run = 1'b0;
            next_done = 1'b1;
          end
          else
            next_unit_cnt = unit_cnt - 8'h01;
        end
        else
          next_us_cnt = us_cnt + 16'h0001;
      end
    end
  end

  // Registers of the divider chain
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      run <= 1'b0;
      pre <= 8'h00;
      us_cnt <= 16'h0000;
      unit_cnt <= 8'h00;
      done_o <= 1'b0;
    end
    else
    begin
      run <= next_run;
      pre <= next_pre;
      us_cnt <= next_us_cnt;
      unit_cnt <= next_unit_cnt;
      done_o <= next_done;
    end
  end
endmodule // tfr_timer
`default_nettype wire

// *** tfr_fault_retry.sv ***
// Over-temperature fault reaction, retry sequencing and warning thresholds
// Notes on behaviour
// - Codes 4-6 retry that often, then latch off
// - Attempts spaced by decoded delay times unit
// - Code 7 retries until off, bias loss, fault
// - Delay code maps to 1,2,4,16,8,32,64,128 units
// - Same delay serves run-on time and spacing
// - Unit length comes from its own register
// - Over-temperature warning threshold at 0x51
// - Under-temperature warning threshold at 0x52
// - Response field selects ignore, delay, retry, latch
// - Code 0 no restart; 1-3 retry then latch
// - Latched fault cleared by bit, command, cycling, bias
`default_nettype none
module tfr_fault_retry (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_cmd_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic clear_faults_i,
  input wire logic operation_on_i,
  input wire logic ctrl_pin_i,
  input wire logic bias_ok_i,
  input wire logic other_fault_i,
  input wire logic ot_fault_i,
  input wire logic [15:0] temp_i,
  output logic output_en_o,
  output logic ot_warn_o,
  output logic ut_warn_o,
  output logic fault_latched_o,
  output logic retrying_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic ctrl_m, ctrl_s; // Control pin, first and second stage
  logic bias_m, bias_s; // Bias good, first and second stage

  // Two flops on each pin; only the second stage is read
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      ctrl_m <= 1'b0;
      ctrl_s <= 1'b0;
      bias_m <= 1'b0;
      bias_s <= 1'b0;
    end
    else
    begin
      ctrl_m <= ctrl_pin_i;
      ctrl_s <= ctrl_m;
      bias_m <= bias_ok_i;
      bias_s <= bias_m;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] reaction; // Fault reaction byte
  logic [15:0] ot_warn_lim; // Over-temperature warning threshold
  logic [15:0] ut_warn_lim; // Under-temperature warning threshold
  logic [15:0] time_unit; // Delay unit length in microseconds
  logic [7:0] status; // Sticky status bits
  logic on_q; // Previous output command, for off-then-on detection
  logic [7:0] next_reaction, next_status;
  logic [15:0] next_ot_warn_lim, next_ut_warn_lim, next_time_unit, next_rdata;
  logic on_cmd; // Output commanded on by pin and command together
  logic cycled_on; // Output turned back on after being off
  logic fault_clear; // Any event that clears the latched fault
  logic ot_hit, ut_hit; // Warning comparisons
  logic fault_set; // Fault latch set from the sequencer

  assign on_cmd = ctrl_s & operation_on_i;
  assign cycled_on = on_cmd & ~on_q;
  // Reads compare signed readings; fault set wins over the status write below
  assign ot_hit = $signed(temp_i) > $signed(ot_warn_lim);
  assign ut_hit = $signed(temp_i) < $signed(ut_warn_lim);
  assign fault_clear = clear_faults_i | cycled_on | ~bias_s |
    (reg_wr_i && reg_cmd_i == tfr_pkg::CMD_STATUS && reg_wdata_i[tfr_pkg::ST_OT_FAULT]);

  // Register writes, status set/clear and read mux
  always_comb
  begin
    next_reaction = reaction;
    next_ot_warn_lim = ot_warn_lim;
    next_ut_warn_lim = ut_warn_lim;
    next_time_unit = time_unit;
    next_status = status;
    next_rdata = reg_rdata_o;
    if (reg_wr_i)
    begin
      case (reg_cmd_i)
        tfr_pkg::CMD_OT_REACTION: next_reaction = reg_wdata_i[7:0];
        tfr_pkg::CMD_OT_WARN: next_ot_warn_lim = reg_wdata_i;
        tfr_pkg::CMD_UT_WARN: next_ut_warn_lim = reg_wdata_i;
        tfr_pkg::CMD_TIME_UNIT: next_time_unit = reg_wdata_i;
        tfr_pkg::CMD_STATUS: next_status = status & ~reg_wdata_i[7:0];
        default: next_status = next_status; // Unmapped write is dropped
      endcase
    end
    if (clear_faults_i)
      next_status = 8'h00;
    // Hardware sets are applied last so a same-cycle clear never loses an event
    if (ot_hit)
      next_status[tfr_pkg::ST_OT_WARN] = 1'b1;
    if (ut_hit)
      next_status[tfr_pkg::ST_UT_WARN] = 1'b1;
    next_status[tfr_pkg::ST_OT_FAULT] = fault_set;
    if (reg_rd_i)
    begin
      case (reg_cmd_i)
        tfr_pkg::CMD_OT_REACTION: next_rdata = {8'h00, reaction};
        tfr_pkg::CMD_OT_WARN: next_rdata = ot_warn_lim;
        tfr_pkg::CMD_UT_WARN: next_rdata = ut_warn_lim;
        tfr_pkg::CMD_TIME_UNIT: next_rdata = time_unit;
        tfr_pkg::CMD_STATUS: next_rdata = {8'h00, status};
        default: next_rdata = 16'h0000; // Unmapped reads return zero
      endcase
    end
  end

  // Register storage
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      reaction <= tfr_pkg::RST_REACTION;
      ot_warn_lim <= tfr_pkg::RST_OT_WARN;
      ut_warn_lim <= tfr_pkg::RST_UT_WARN;
      time_unit <= tfr_pkg::RST_TIME_UNIT;
      status <= 8'h00;
      on_q <= 1'b0;
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reaction <= next_reaction;
      ot_warn_lim <= next_ot_warn_lim;
      ut_warn_lim <= next_ut_warn_lim;
      time_unit <= next_time_unit;
      status <= next_status;
      on_q <= on_cmd;
      reg_rdata_o <= next_rdata;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // ----------------------------------------------------------------
  // Retry sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'h0, // Normal operation
    ST_RUNON = 3'h1, // Running on through the delay
    ST_WAIT = 3'h2, // Output off, waiting for the next attempt
    ST_TRY = 3'h3, // Restart attempt in progress
    ST_LATCH = 3'h4 // Off until the fault is cleared
  } tfr_state_type;

  tfr_state_type state, next_state;
  logic [2:0] tries, next_tries; // Attempts made so far
  logic tmr_start, tmr_done; // Restart the delay timer, delay elapsed
  logic [1:0] resp;
  logic [2:0] retry;
  logic more_tries; // Another attempt is allowed

  assign resp = reaction[tfr_pkg::RESP_MSB:tfr_pkg::RESP_LSB];
  assign retry = reaction[tfr_pkg::RETRY_MSB:tfr_pkg::RETRY_LSB];
  assign more_tries = (retry == tfr_pkg::RETRY_FOREVER) || (tries < retry);

  // One timer serves both the run-on time and the attempt spacing
  tfr_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .start_i(tmr_start),
    .units_i(tfr_pkg::delay_units(reaction[tfr_pkg::DELAY_MSB:tfr_pkg::DELAY_LSB])),
    .unit_us_i(time_unit),
    .done_o(tmr_done)
  );

  // Next state of the sequencer
  always_comb
  begin
    next_state = state;
    next_tries = tries;
    tmr_start = 1'b0;
    case (state)
      ST_RUN:
      begin
        next_tries = 3'h0;
        if (ot_fault_i && on_cmd && bias_s)
        begin
          case (resp)
            tfr_pkg::RESP_DELAY:
            begin
              next_state = ST_RUNON;
              tmr_start = 1'b1;
            end
            tfr_pkg::RESP_RETRY:
            begin
              next_state = (retry == tfr_pkg::RETRY_NONE) ? ST_LATCH : ST_WAIT;
              tmr_start = 1'b1;
            end
            tfr_pkg::RESP_LATCH: next_state = ST_LATCH;
            default: next_state = ST_RUN; // Fault ignored
          endcase
        end
      end
      ST_RUNON:
      begin
        // Keep running; at the end act on the retry setting if still faulted
        if (tmr_done)
        begin
          if (!ot_fault_i)
            next_state = ST_RUN;
          else if (retry == tfr_pkg::RETRY_NONE)
            next_state = ST_LATCH;
          else
          begin
            next_state = ST_WAIT;
            tmr_start = 1'b1;
          end
        end
      end
      ST_WAIT:
      begin
        // Output off; the next attempt starts one interval after the last start
        if (tmr_done)
        begin
          if (more_tries)
          begin
            next_state = ST_TRY;
            next_tries = tries + 3'h1; // Wrap is harmless: unlimited mode ignores the count
            tmr_start = 1'b1;
          end
          else
            next_state = ST_LATCH;
        end
      end
      ST_TRY:
      begin
        // A fault seen during the attempt fails it at once, so every attempt is a real restart
        if (ot_fault_i)
        begin
          next_state = ST_WAIT;
          tmr_start = tmr_done; // Interval already over: give the off time a full one
        end
        else if (tmr_done)
          next_state = ST_RUN;
      end
      ST_LATCH: next_state = ST_LATCH; // Left only through a clear, below
      default: next_state = ST_RUN;
    endcase
    // Off command, bias loss or another fault stop any retrying
    if (state != ST_RUN && state != ST_LATCH && (!on_cmd || !bias_s))
      next_state = ST_RUN;
    if (state != ST_RUN && other_fault_i)
      next_state = ST_LATCH;
    if (fault_clear && state == ST_LATCH)
      next_state = ST_RUN;
  end

  // Sequencer registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      state <= ST_RUN;
      tries <= 3'h0;
    end
    else
    begin
      state <= next_state;
      tries <= next_tries;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign fault_set = (next_state == ST_LATCH);
  assign fault_latched_o = status[tfr_pkg::ST_OT_FAULT];
  assign ot_warn_o = status[tfr_pkg::ST_OT_WARN];
  assign ut_warn_o = status[tfr_pkg::ST_UT_WARN];
  assign retrying_o = (state == ST_WAIT) || (state == ST_TRY);
  // Output runs in normal, run-on and attempt states only; warnings never stop it
  assign output_en_o = on_cmd && bias_s &&
    (state == ST_RUN || state == ST_RUNON || state == ST_TRY);
endmodule // tfr_fault_retry
`default_nettype wire

// *** tfr_monitor.sv ***
// Port checker of the temperature fault retry block
`default_nettype none
module tfr_monitor (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_cmd_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic clear_faults_i,
  input wire logic operation_on_i,
  input wire logic ctrl_pin_i,
  input wire logic bias_ok_i,
  input wire logic output_en_o,
  input wire logic ot_warn_o,
  input wire logic fault_latched_o,
  input wire logic retrying_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Clock and reset of every check
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // Write, one idle cycle, read back of the same threshold
  sequence ot_wr_rd_s;
    reg_wr_i && reg_cmd_i == tfr_pkg::CMD_OT_WARN ##1 !reg_wr_i
      ##1 reg_rd_i && !reg_wr_i && reg_cmd_i == tfr_pkg::CMD_OT_WARN;
  endsequence
  sequence ut_wr_rd_s;
    reg_wr_i && reg_cmd_i == tfr_pkg::CMD_UT_WARN ##1 !reg_wr_i
      ##1 reg_rd_i && !reg_wr_i && reg_cmd_i == tfr_pkg::CMD_UT_WARN;
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered in the next cycle");
  read_quiet_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("read valid without a read");
  ot_readback_a: assert property (ot_wr_rd_s |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("over threshold read back differs");
  ut_readback_a: assert property (ut_wr_rd_s |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("under threshold read back differs");
  latch_off_a: assert property (fault_latched_o |-> !output_en_o)
    else $error("output on while fault latched");
  // Held on-command and bias for four cycles rule out a clearing off-on cycle
  latch_hold_a: assert property ((bias_ok_i && ctrl_pin_i && operation_on_i)[*4] ##0
    (fault_latched_o && !clear_faults_i && !reg_wr_i) |=> fault_latched_o)
    else $error("latched fault dropped without a clear");
  clear_event_a: assert property (clear_faults_i |=> !fault_latched_o)
    else $error("clear event left the fault latched");
  warn_hold_a: assert property (ot_warn_o && !clear_faults_i && !reg_wr_i |=> ot_warn_o)
    else $error("warning dropped without a clear");
  off_stops_a: assert property ((!operation_on_i)[*5] |-> !output_en_o && !retrying_o)
    else $error("retry or output kept while commanded off");
  // Main scenarios reached
  cover property (fault_latched_o);
  cover property ($rose(retrying_o));
  cover property ($rose(ot_warn_o));
endmodule // tfr_monitor
bind tfr_fault_retry tfr_monitor mon (.*);
`default_nettype wire

// *** tfr_host_model.sv ***
// Register host model that drives the command port of the block
`default_nettype none
module tfr_host_model (
  input wire logic ref_clk_i,
  output logic [7:0] reg_cmd_o,
  output logic reg_wr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial
  begin
    reg_cmd_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 16'h0000;
    reg_rd_o = 1'b0;
  end
  // One strobed access; the released bus is inverted so stale data never passes
  // Status clears are written through here as write-one-to-clear
  task automatic access(input logic wr, input logic [7:0] c, input logic [15:0] d);
    @(negedge ref_clk_i);
    reg_cmd_o = c;
    reg_wdata_o = d;
    reg_wr_o = wr;
    reg_rd_o = !wr;
    @(negedge ref_clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_cmd_o = ~c;
    reg_wdata_o = ~d;
  endtask
endmodule // tfr_host_model
`default_nettype wire

// *** temperature_fault_retry_logic_test.sv ***
// Self-checking bench of the temperature fault retry block
`default_nettype none
module temperature_fault_retry_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, resetn_i, clear_faults_i, operation_on_i, ctrl_pin_i;
  logic bias_ok_i, other_fault_i, ot_fault_i, reg_wr_i, reg_rd_i;
  logic [7:0] reg_cmd_i;
  logic [15:0] reg_wdata_i, temp_i, reg_rdata_o;
  logic reg_rvalid_o, output_en_o, ot_warn_o, ut_warn_o, fault_latched_o, retrying_o;
  logic [15:0] exp_q[$]; // Expected read data, oldest first
  int n_fail = 0;
  int n_checks = 0;
  int n, att;
  logic prev;
  logic [31:0] seed = 32'h9361;
  localparam int UNITS [8] = '{1, 2, 4, 16, 8, 32, 64, 128};
  // ------------------------------------------------------------
  // Design, host and clock
  // ------------------------------------------------------------
  tfr_host_model host (.ref_clk_i(ref_clk_i), .reg_cmd_o(reg_cmd_i), .reg_wr_o(reg_wr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));
  tfr_fault_retry dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_cmd_i(reg_cmd_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .clear_faults_i(clear_faults_i),
    .operation_on_i(operation_on_i), .ctrl_pin_i(ctrl_pin_i), .bias_ok_i(bias_ok_i),
    .other_fault_i(other_fault_i), .ot_fault_i(ot_fault_i), .temp_i(temp_i),
    .output_en_o(output_en_o), .ot_warn_o(ot_warn_o), .ut_warn_o(ut_warn_o),
    .fault_latched_o(fault_latched_o), .retrying_o(retrying_o));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return (s << 1) ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction
  task automatic idle(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask
  // Reads note their expectation first; the watcher pairs it with the answer
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    host.access(1'b0, c, 16'h0000);
  endtask
  task automatic reac(input logic [7:0] v);
    host.access(1'b1, tfr_pkg::CMD_OT_REACTION, {8'h00, v});
  endtask
  task automatic pulse_clear();
    clear_faults_i = 1'b1;
    @(negedge ref_clk_i);
    clear_faults_i = 1'b0;
  endtask
  // Bounded wait for the output enable to reach a level
  task automatic wait_en(input logic lv, input int lim, output int c);
    c = 0;
    while (output_en_o !== lv && c < lim)
    begin
      @(negedge ref_clk_i);
      c++;
    end
  endtask
  // Read answers are compared with the oldest note
  always @(negedge ref_clk_i)
    if (reg_rvalid_o === 1'b1)
      check(reg_rdata_o, exp_q.size() > 0 ? exp_q.pop_front() : ~reg_rdata_o);
  // Hang guard sized above the longest retry intervals
  initial
  begin
    repeat (90000) @(negedge ref_clk_i);
    n_fail++;
    test_done();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {resetn_i, clear_faults_i, other_fault_i, ot_fault_i} = 4'h0;
    {operation_on_i, ctrl_pin_i, bias_ok_i} = 3'h7;
    temp_i = 16'h0000;
    idle(20);
    resetn_i = 1'b1;
    idle(5);
    // Reset contents and an unmapped code
    rd(tfr_pkg::CMD_OT_REACTION, tfr_pkg::RST_REACTION);
    rd(tfr_pkg::CMD_OT_WARN, 16'h0064);
    rd(tfr_pkg::CMD_UT_WARN, 16'hffd8);
    rd(tfr_pkg::CMD_TIME_UNIT, 16'h03e8);
    rd(8'h33, 16'h0000);
    host.access(1'b1, tfr_pkg::CMD_TIME_UNIT, 16'h0001); // One unit is 125 cycles
    rd(tfr_pkg::CMD_TIME_UNIT, 16'h0001);
    seed = lfsr(seed);
    host.access(1'b1, tfr_pkg::CMD_OT_WARN, seed[15:0]);
    rd(tfr_pkg::CMD_OT_WARN, seed[15:0]);
    host.access(1'b1, tfr_pkg::CMD_UT_WARN, seed[31:16]);
    rd(tfr_pkg::CMD_UT_WARN, seed[31:16]);
    host.access(1'b1, tfr_pkg::CMD_OT_WARN, 16'h0064);
    host.access(1'b1, tfr_pkg::CMD_UT_WARN, 16'hffd8);
    // Both warnings flag while the output stays on
    temp_i = 16'h0065;
    idle(3);
    check(ot_warn_o, 1'b1);
    temp_i = 16'hffd0;
    idle(3);
    check(ut_warn_o, 1'b1);
    check(output_en_o, 1'b1);
    temp_i = 16'h0000;
    pulse_clear();
    idle(3);
    rd(tfr_pkg::CMD_STATUS, 16'h0000);
    // Attempt counts 0..6, cleared in turn by pulse, status bit, off-on cycle, bias loss
    for (int k = 0; k < 7; k++)
    begin
      reac({2'h2, 3'(k), 3'h0});
      ot_fault_i = 1'b1;
      att = 0;
      prev = 1'b1;
      for (int t = 0; t < 2000 && fault_latched_o !== 1'b1; t++)
      begin
        @(negedge ref_clk_i);
        if (output_en_o === 1'b1 && prev !== 1'b1)
          att++;
        prev = output_en_o;
      end
      check(16'(att), 16'(k));
      check(output_en_o, 1'b0);
      ot_fault_i = 1'b0;
      case (k % 4)
        0: pulse_clear();
        1: host.access(1'b1, tfr_pkg::CMD_STATUS, 16'h0080);
        2: begin operation_on_i = 1'b0; idle(8); operation_on_i = 1'b1; end
        default: begin bias_ok_i = 1'b0; idle(8); bias_ok_i = 1'b1; end
      endcase
      idle(10);
      check(fault_latched_o, 1'b0);
    end
    // Spacing of attempts for every delay code, then a successful restart
    for (int d = 0; d < 8; d++)
    begin
      reac({5'h11, 3'(d)});
      ot_fault_i = 1'b1;
      wait_en(1'b0, 10, n);
      wait_en(1'b1, 17000, n);
      check(16'((n + 10) / 125), 16'(UNITS[d]));
      ot_fault_i = 1'b0;
      idle(UNITS[d] * 125 + 20);
      check({fault_latched_o, output_en_o}, 2'h1);
    end
    // Latch at once, ignore, then run on for the delay
    reac(8'hc0);
    ot_fault_i = 1'b1;
    idle(3);
    check(fault_latched_o, 1'b1);
    ot_fault_i = 1'b0;
    pulse_clear();
    reac(8'h00);
    ot_fault_i = 1'b1;
    idle(200);
    check({output_en_o, retrying_o}, 2'h2);
    reac(8'h48);
    idle(100);
    check(output_en_o, 1'b1);
    idle(60);
    check(output_en_o, 1'b0);
    ot_fault_i = 1'b0;
    idle(300);
    check(output_en_o, 1'b1);
    // Unlimited retries stop on an off command and on another fault
    reac(tfr_pkg::RST_REACTION);
    ot_fault_i = 1'b1;
    idle(2000);
    check({fault_latched_o, retrying_o}, 2'h1);
    bias_ok_i = 1'b0;
    idle(8);
    check({output_en_o, retrying_o}, 2'h0);
    bias_ok_i = 1'b1;
    idle(8);
    operation_on_i = 1'b0;
    idle(8);
    check({output_en_o, retrying_o}, 2'h0);
    operation_on_i = 1'b1;
    idle(8);
    other_fault_i = 1'b1;
    idle(3);
    check(fault_latched_o, 1'b1);
    {other_fault_i, ot_fault_i} = 2'h0;
    pulse_clear();
    idle(5);
    check(16'(exp_q.size()), 16'h0000);
    test_done();
  end
endmodule // temperature_fault_retry_logic_test
`default_nettype wire
